//--- bench/spi_pin_and_select_modes_test.sv
// self-checking bench for the spi pin and select mode port
`timescale 1ns/1ps
module spi_pin_and_select_modes_test;
  import spips_pkg::*;
  logic        i_core_clk, i_reset_n, i_ctrl_wr, i_port_en, i_master_en;
  logic        i_fault_clr, i_start, o_port_en, o_master_en, o_fault;
  logic        o_busy, o_sel_routed, o_done, o_sck, o_sck_oe, o_mosi;
  logic        o_mosi_oe, o_miso, o_miso_oe, o_sel_n, o_sel_oe;
  logic        f_sck, f_mosi, f_miso, f_sel_n;
  spips_mode_t i_sel_mode, o_sel_mode;
  spips_byte_t i_tx_data, o_rx_data, got;
  int          miscompares = 0, num_checks = 0, cycles = 0, dones = 0, d0;
  integer      seed;
  wire sck_w  = o_sck_oe ? o_sck : f_sck;
  wire mosi_w = o_mosi_oe ? o_mosi : f_mosi;
  wire miso_w = o_miso_oe ? o_miso : f_miso;
  wire sel_w  = o_sel_oe ? o_sel_n : f_sel_n;

  spips_port u_spips_port (.i_core_clk, .i_reset_n, .i_ctrl_wr, .i_port_en,
    .i_master_en, .i_sel_mode, .i_fault_clr, .o_port_en, .o_master_en,
    .o_sel_mode, .o_fault, .o_busy, .o_sel_routed, .i_start, .i_tx_data,
    .o_rx_data, .o_done, .i_sck(sck_w), .o_sck, .o_sck_oe, .i_mosi(mosi_w),
    .o_mosi, .o_mosi_oe, .i_miso(miso_w), .o_miso, .o_miso_oe,
    .i_sel_n(sel_w), .o_sel_n, .o_sel_oe);
  spips_far_end u_spips_far_end (.i_sck(sck_w), .i_mosi(mosi_w),
    .i_miso(miso_w), .o_sck(f_sck), .o_mosi(f_mosi), .o_miso(f_miso),
    .o_sel_n(f_sel_n));

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (o_done === 1'b1)
      dones <= dones + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // select pin is routed in every mode but 3-wire
  function automatic logic routed_exp(input spips_mode_t m);
    return m != 2'h0;
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task ctrl(input logic pe, input logic me, input spips_mode_t m);
    @(posedge i_core_clk);
    i_ctrl_wr <= 1'b1;
    i_port_en <= pe;
    i_master_en <= me;
    i_sel_mode <= m;
    @(posedge i_core_clk);
    i_ctrl_wr <= 1'b0;
    @(negedge i_core_clk);
  endtask
  task pulse_start(input spips_byte_t b);
    @(posedge i_core_clk);
    i_start <= 1'b1;
    i_tx_data <= b;
    @(posedge i_core_clk);
    i_start <= 1'b0;
  endtask
  // second start while busy must be dropped
  task mxfer(input spips_byte_t tx, input spips_byte_t rep);
    u_spips_far_end.load(rep);
    d0 = dones;
    pulse_start(tx);
    @(negedge i_core_clk);
    chk(o_busy, 1'b1);
    pulse_start(~tx);
    repeat (80) @(negedge i_core_clk);
    chk(8'(dones - d0), 8'h01);
    chk(o_rx_data, rep);
    chk(u_spips_far_end.rx, tx);
  endtask
  task sxfer(input spips_byte_t tx, input spips_byte_t rep,
             input logic sel, input logic [7:0] n);
    pulse_start(rep);
    d0 = dones;
    @(negedge i_core_clk);
    u_spips_far_end.frame(tx, sel, got);
    repeat (4) @(negedge i_core_clk);
    chk(8'(dones - d0), n);
    if (n != 0) begin
      chk(o_rx_data, tx);
      chk(got, rep);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 57004;
    {i_reset_n, i_ctrl_wr, i_port_en, i_master_en, i_fault_clr} = 5'h00;
    {i_start, i_sel_mode, i_tx_data} = 11'h000;
    repeat (10) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    @(negedge i_core_clk);
    chk(o_sel_mode, 8'h01);
    chk(o_sel_routed, 1'b1);
    chk(o_sel_oe, 1'b0);
    chk(o_miso_oe, 1'b0);
    @(posedge i_core_clk);
    for (int m = 0; m < 4; m++) begin
      ctrl(1'b1, 1'b1, m[1:0]);
      chk(o_sel_routed, routed_exp(m[1:0]));
      chk(o_sel_oe, m[1]);
      chk(o_sck_oe, 1'b1);
      chk(o_mosi_oe, 1'b1);
      chk(o_miso_oe, 1'b0);
      if (m[1])
        chk(sel_w, m[0]);
      mxfer(m == 0 ? 8'h80 : 8'($random(seed)),
            m == 0 ? 8'h01 : 8'($random(seed)));
    end
    // master knocked out by select falling mid-byte
    ctrl(1'b1, 1'b1, 2'h1);
    d0 = dones;
    pulse_start(8'hA5);
    repeat (10) @(negedge i_core_clk);
    u_spips_far_end.set_sel(1'b0);
    repeat (20) @(negedge i_core_clk);
    chk(o_port_en, 1'b0);
    chk(o_master_en, 1'b0);
    chk(o_fault, 1'b1);
    chk(o_sck_oe, 1'b0);
    repeat (60) @(negedge i_core_clk);
    chk(8'(dones - d0), 8'h00);
    u_spips_far_end.set_sel(1'b1);
    @(posedge i_core_clk);
    i_fault_clr <= 1'b1;
    @(posedge i_core_clk);
    i_fault_clr <= 1'b0;
    @(negedge i_core_clk);
    chk(o_fault, 1'b0);
    ctrl(1'b1, 1'b0, 2'h1);
    chk(o_miso_oe, 1'b0);
    chk(o_mosi_oe, 1'b0);
    sxfer(8'h3C, 8'hC3, 1'b0, 8'h00);
    for (int k = 0; k < 2; k++)
      sxfer(8'($random(seed)), 8'($random(seed)), 1'b1, 8'h01);
    ctrl(1'b1, 1'b0, 2'h0);
    chk(o_miso_oe, 1'b1);
    chk(o_sel_routed, 1'b0);
    sxfer(8'($random(seed)), 8'($random(seed)), 1'b0, 8'h01);
    ctrl(1'b0, 1'b0, 2'h0);
    chk(o_miso_oe, 1'b0);
    give_verdict;
  end
endmodule

//--- bench/spips_far_end.sv
// far-side spi device model, acting as slave or as master
`timescale 1ns/1ps
module spips_far_end (
  // link lines in
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_miso,
  // link lines out
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_miso,
  output logic      o_sel_n
);
  import spips_pkg::*;
  spips_byte_t sr;
  spips_byte_t rx;
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_sel_n = 1'b1;
    sr = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // slave side, the only slave on the bus
  assign o_miso = sr[7];
  always @(posedge i_sck) rx <= {rx[6:0], i_mosi};
  always @(negedge i_sck) sr <= {sr[6:0], ~sr[0]};
  task automatic load(input spips_byte_t b);
    sr = b;
  endtask
  task automatic set_sel(input logic v);
    o_sel_n = v;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // master side, sck still outside frames
  task automatic frame(input spips_byte_t tx, input logic sel,
                       output spips_byte_t got);
    if (sel)
      o_sel_n = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #62.5 o_sck = 1'b1;
      got = {got[6:0], i_miso};
      #62.5 o_sck = 1'b0;
    end
    o_mosi = ~o_mosi;
    #250 o_sel_n = 1'b1;
  endtask
endmodule

//--- hdl/spips_consts.svh
// constants for the spi pin and select mode port
`ifndef SPIPS_CONSTS_SVH
`define SPIPS_CONSTS_SVH
`define SPIPS_MODE_3WIRE     2'h0
`define SPIPS_MODE_4W_INPUT  2'h1
`define SPIPS_MODE_HI_BIT    1
`define SPIPS_MODE_LO_BIT    0
`define SPIPS_BYTE_MSB       7
`define SPIPS_LAST_BIT       3'h7
`define SPIPS_CLK_NS         25
`define SPIPS_SCK_HALF_NS    100
`define SPIPS_SCK_HALF_CYC   ((`SPIPS_SCK_HALF_NS + `SPIPS_CLK_NS - 1) / `SPIPS_CLK_NS)
`endif

//--- hdl/spips_pkg.sv
// types for the spi pin and select mode port
package spips_pkg;
  typedef logic [1:0] spips_mode_t;
  typedef logic [7:0] spips_byte_t;
  typedef enum logic [2:0] {
    SPIPS_IDLE = 3'h1,
    SPIPS_LOW  = 3'h2,
    SPIPS_HIGH = 3'h4
  } spips_state_t;
endpackage

//--- hdl/spips_port.sv
// spi port with master, slave and slave-select mode handling
//
// Summary of operation
// - master drives the mosi line, slave takes mosi as input.
// - master mosi always shows the shift register msb.
// - master takes miso as input, slave drives miso.
// - bytes shift msb first in both directions.
// - miso floats when disabled or as unselected 4-wire slave.
// - 3-wire slave always drives miso, from the stx_q msb while the bit counter is 0, else from the shift register msb.
// - master makes sck itself; slave takes sck from the master.
// - 4-wire slave ignores sck while select input is high.
// - select mode 00 gives 3-wire master or slave, select unused.
// - 3-wire slave acts as always selected.
// - select mode 01 gives 4-wire operation, select pin is input.
// - 4-wire slave is selected only while select input is low.
// - master in mode 01 drops master function on select falling.
// - select mode 1x gives 4-wire operation, select pin is output.
// - output select level equals the low select mode bit.
// - select routed to a pin in every mode except 3-wire.
// - mode fault clears master and port enable, sets fault flag.
// - 4-wire slave bit counter is held cleared while select input is high.
`timescale 1ns/1ps
`include "spips_consts.svh"
module spips_port (
  // core clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset_n,
  // control writes
  input  wire logic                  i_ctrl_wr,
  input  wire logic                  i_port_en,
  input  wire logic                  i_master_en,
  input  wire spips_pkg::spips_mode_t i_sel_mode,
  input  wire logic                  i_fault_clr,
  // control and status
  output logic                       o_port_en,
  output logic                       o_master_en,
  output spips_pkg::spips_mode_t     o_sel_mode,
  output logic                       o_fault,
  output logic                       o_busy,
  output logic                       o_sel_routed,
  // data
  input  wire logic                  i_start,
  input  wire spips_pkg::spips_byte_t i_tx_data,
  output spips_pkg::spips_byte_t     o_rx_data,
  output logic                       o_done,
  // link pins
  input  wire logic                  i_sck,
  output logic                       o_sck,
  output logic                       o_sck_oe,
  input  wire logic                  i_mosi,
  output logic                       o_mosi,
  output logic                       o_mosi_oe,
  input  wire logic                  i_miso,
  output logic                       o_miso,
  output logic                       o_miso_oe,
  input  wire logic                  i_sel_n,
  output logic                       o_sel_n,
  output logic                       o_sel_oe
);
  import spips_pkg::*;

  localparam logic [2:0] HALF_LAST = 3'(`SPIPS_SCK_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // control registers and pin synchronisers
  logic         port_en_q;
  logic         master_q;
  spips_mode_t  mode_q;
  logic         fault_q;
  logic         sel_s1_q;
  logic         sel_s2_q;
  logic         sel_s3_q;
  logic         miso_s1_q;
  logic         miso_s2_q;

  wire mode_3wire   = (mode_q == `SPIPS_MODE_3WIRE);
  wire mode_4w_in   = (mode_q == `SPIPS_MODE_4W_INPUT);
  wire mode_4w_out  = mode_q[`SPIPS_MODE_HI_BIT];
  wire is_master    = port_en_q & master_q;
  wire is_slave     = port_en_q & ~master_q;
  wire sel_fall     = sel_s3_q & ~sel_s2_q;
  wire fault_event  = is_master & mode_4w_in & sel_fall;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_s1_q  <= 1'h1;
      sel_s2_q  <= 1'h1;
      sel_s3_q  <= 1'h1;
      miso_s1_q <= 1'h0;
      miso_s2_q <= 1'h0;
    end else begin
      sel_s1_q  <= i_sel_n;
      sel_s2_q  <= sel_s1_q;
      sel_s3_q  <= sel_s2_q;
      miso_s1_q <= i_miso;
      miso_s2_q <= miso_s1_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port_en_q <= 1'h0;
      master_q  <= 1'h0;
      mode_q    <= `SPIPS_MODE_4W_INPUT;
      fault_q   <= 1'h0;
    end else begin
      if (fault_event) begin
        port_en_q <= 1'h0;
        master_q  <= 1'h0;
      end else if (i_ctrl_wr) begin
        port_en_q <= i_port_en;
        master_q  <= i_master_en;
        mode_q    <= i_sel_mode;
      end
      // set wins over clear
      fault_q <= fault_event | (fault_q & ~i_fault_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // master engine, sck made from the core clock
  spips_state_t state_q;
  logic [2:0]   div_q;
  logic [2:0]   mbit_q;
  spips_byte_t  msh_q;
  logic         mrx_bit_q;
  logic         sck_q;
  logic         mdone;
  logic [2:0]   mbit_d;

  wire half_end = (div_q == HALF_LAST);
  assign mbit_d = mbit_q + 3'h1;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q   <= SPIPS_IDLE;
      div_q     <= 3'h0;
      mbit_q    <= 3'h0;
      msh_q     <= 8'h00;
      mrx_bit_q <= 1'h0;
      sck_q     <= 1'h0;
    end else begin
      div_q <= half_end ? 3'h0 : div_q + 3'h1;
      case (state_q)
        SPIPS_IDLE: begin
          div_q  <= 3'h0;
          mbit_q <= 3'h0;
          if (i_start && is_master) begin
            msh_q   <= i_tx_data;
            state_q <= SPIPS_LOW;
          end
        end
        SPIPS_LOW: begin
          if (!is_master) begin
            state_q <= SPIPS_IDLE;
          end else if (half_end) begin
            sck_q     <= 1'h1;
            mrx_bit_q <= miso_s2_q;
            state_q   <= SPIPS_HIGH;
          end
        end
        SPIPS_HIGH: begin
          if (!is_master || half_end) begin
            sck_q   <= 1'h0;
            state_q <= SPIPS_LOW;
          end
          if (!is_master) begin
            state_q <= SPIPS_IDLE;
          end else if (half_end) begin
            msh_q  <= {msh_q[6:0], mrx_bit_q};
            mbit_q <= mbit_d;
            if (mbit_q == `SPIPS_LAST_BIT) begin
              state_q <= SPIPS_IDLE;
            end
          end
        end
        default: begin
          state_q <= SPIPS_IDLE;
          sck_q   <= 1'h0;
        end
      endcase
    end
  end

  assign mdone = (state_q == SPIPS_HIGH) & is_master & half_end
               & (mbit_q == `SPIPS_LAST_BIT);

  ////////////////////////////////////////////////////////////////////////
  // slave engine on the link clock
  spips_byte_t  stx_q;
  spips_byte_t  ssh_q;
  spips_byte_t  srx_q;
  logic [2:0]   sbit_q;
  logic         srx_bit_q;
  logic         stgl_q;
  logic         slv_sel;
  logic         link_rst_n;

  // 3-wire slave is always selected, 4-wire needs select low
  assign slv_sel    = mode_3wire | (mode_4w_in & ~i_sel_n);
  // held in reset while unselected: sck ignored, counter cleared
  assign link_rst_n = i_reset_n & is_slave & slv_sel;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stx_q <= 8'h00;
    end else if (i_start && is_slave) begin
      stx_q <= i_tx_data;
    end
  end

  always_ff @(posedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      srx_bit_q <= 1'h0;
    end else begin
      srx_bit_q <= i_mosi;
    end
  end

  always_ff @(negedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ssh_q  <= 8'h00;
      sbit_q <= 3'h0;
    end else begin
      sbit_q <= sbit_q + 3'h1;
      if (sbit_q == 3'h0) begin
        ssh_q <= {stx_q[6:0], srx_bit_q};
      end else begin
        ssh_q <= {ssh_q[6:0], srx_bit_q};
      end
    end
  end

  always_ff @(negedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      srx_q  <= 8'h00;
      stgl_q <= 1'h0;
    end else if (link_rst_n && sbit_q == `SPIPS_LAST_BIT) begin
      srx_q  <= {ssh_q[6:0], srx_bit_q};
      stgl_q <= ~stgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte-done crossing and received data
  logic t_s1_q;
  logic t_s2_q;
  logic t_s3_q;
  wire  sdone = t_s2_q ^ t_s3_q;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      t_s1_q    <= 1'h0;
      t_s2_q    <= 1'h0;
      t_s3_q    <= 1'h0;
      o_done    <= 1'h0;
      o_rx_data <= 8'h00;
    end else begin
      t_s1_q <= stgl_q;
      t_s2_q <= t_s1_q;
      t_s3_q <= t_s2_q;
      o_done <= mdone | (sdone & is_slave);
      if (mdone) begin
        o_rx_data <= {msh_q[6:0], mrx_bit_q};
      end else if (sdone && is_slave) begin
        o_rx_data <= srx_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and status
  assign o_port_en    = port_en_q;
  assign o_master_en  = master_q;
  assign o_sel_mode   = mode_q;
  assign o_fault      = fault_q;
  assign o_busy       = (state_q != SPIPS_IDLE);
  assign o_sck        = sck_q;
  assign o_sck_oe     = is_master;
  assign o_mosi       = msh_q[`SPIPS_BYTE_MSB];
  assign o_mosi_oe    = is_master;
  assign o_miso       = (sbit_q == 3'h0) ? stx_q[`SPIPS_BYTE_MSB]
                                         : ssh_q[`SPIPS_BYTE_MSB];
  assign o_miso_oe    = is_slave
                      & (mode_3wire | (mode_4w_in & ~sel_s2_q));
  assign o_sel_n      = mode_q[`SPIPS_MODE_LO_BIT];
  assign o_sel_oe     = mode_4w_out;
  assign o_sel_routed = ~mode_3wire;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_mosi_dir: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) i_ctrl_wr && !fault_event
    |=> o_mosi_oe == ($past(i_port_en) && $past(i_master_en)))
    else $error("mosi direction");
  a_mosi_shift: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) state_q == SPIPS_HIGH && half_end && is_master
    |=> o_mosi == $past(msh_q[`SPIPS_BYTE_MSB - 1]))
    else $error("mosi not next bit");
  a_miso_master: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) master_q |-> !o_miso_oe)
    else $error("miso driven as master");
  a_miso_float: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) !port_en_q || (mode_4w_in && sel_s2_q)
    |-> !o_miso_oe) else $error("miso not floating");
  a_miso_3wire: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) is_slave && mode_3wire |-> o_miso_oe)
    else $error("3-wire slave miso floating");
  a_sck_owner: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) state_q == SPIPS_IDLE |-> !o_sck)
    else $error("sck high while idle");
  a_fault_drop: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n) fault_event
    |=> !master_q && !port_en_q && fault_q ##1 state_q == SPIPS_IDLE)
    else $error("mode fault not handled");
  a_sel_output: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n)
    i_ctrl_wr && !fault_event && i_sel_mode[`SPIPS_MODE_HI_BIT]
    |=> o_sel_oe && o_sel_n == $past(i_sel_mode[`SPIPS_MODE_LO_BIT]))
    else $error("select output level");
  a_sel_route: assert property (@(posedge i_core_clk)
    disable iff (!i_reset_n)
    o_sel_routed == (mode_q != `SPIPS_MODE_3WIRE)
    && !(o_sel_oe && !mode_q[`SPIPS_MODE_HI_BIT]))
    else $error("select routing");
endmodule
